// [sbs_scan_unit.sv]
// Purpose: test access port with instruction decode and data register selection
// Assumes: tck well below core_clk/4; memory pin levels stable during capture
// Notes: private codes select the bypass register; no test reset pin exists
`timescale 1ns/1ps

// Operation
// - code 000 selects the external test instruction.
// - memory input pins keep working; scan never blocks them.
// - external test drives boundary contents on outputs at falling tck in update-ir.
// - external test capture-dr loads pin levels and defaults into boundary register.
// - during external test each output drives its boundary cell value.
// - code 001 captures identification value and shifts it between tdi and tdo.
// - identification instruction is current after reset and in test-logic-reset.
// - code 010 floats memory outputs and shifts the boundary register.
// - code 100 captures the pin ring and shifts it, outputs not floated.
// - code 111 places the one-bit bypass register in the serial path.
// - instruction codes are binary, msb leftmost, lsb rightmost.
// - instruction register is three bits; capture-ir loads 01 in the low bits.
// - identification register is 32 bits, bit zero shifted out first.
// - scan registers sample tdi on rising tck, change tdo on falling tck.
module sbs_scan_unit import sbs_pkg::*; #(
  parameter int BSR_LEN = 16,
  parameter logic [BSR_LEN-1:0] BSR_PIN_MASK = '1,
  parameter logic [BSR_LEN-1:0] BSR_DEFAULT = '1,
  parameter logic [31:0] ID_VALUE = SBS_ID_DEFAULT
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // test port pins
  input wire sbs_pins_s pins,
  output sbs_tdo_s tdo_pin,
  // memory pin ring
  input wire logic [BSR_LEN-1:0] ring_in,
  output logic [BSR_LEN-1:0] ring_out,
  output logic scan_drive,
  output logic outputs_float,
  // current instruction
  output logic [SBS_IR_W-1:0] instr
);

  sbs_pins_s pins_q;
  logic [BSR_LEN-1:0] ring_q;
  logic tck_prev;
  logic tck_rise;
  logic tck_fall;
  sbs_tap_e state;
  sbs_tap_e next_state;
  logic [SBS_IR_W-1:0] ir_shift;
  logic [BSR_LEN-1:0] bsr;
  logic [SBS_ID_W-1:0] id_shift;
  logic bypass_bit;
  sbs_path_e path;

  // refuse a boundary register too short to shift
  if (BSR_LEN < 2) begin : g_len_check
    $error("sbs_scan_unit: boundary register needs at least two cells");
  end

  function automatic sbs_path_e path_of(input logic [SBS_IR_W-1:0] code);
    case (code)
      SBS_OP_EXTERNAL, SBS_OP_SAMPLE_FLOAT, SBS_OP_PRELOAD: path_of = PATH_BOUNDARY;
      SBS_OP_IDENT: path_of = PATH_IDENT;
      SBS_OP_BYPASS: path_of = PATH_BYPASS;
      default: path_of = PATH_BYPASS;
    endcase
  endfunction : path_of

  sbs_sync #(.W(3)) u_pin_sync (
    .core_clk(core_clk),
    .srst(srst),
    .din(pins),
    .dout(pins_q)
  );

  // memory ring is only observed, never gated
  sbs_sync #(.W(BSR_LEN)) u_ring_sync (
    .core_clk(core_clk),
    .srst(srst),
    .din(ring_in),
    .dout(ring_q)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tck_prev <= 1'b0;
    end else begin
      tck_prev <= pins_q.tck;
    end
  end

  assign tck_rise = pins_q.tck & ~tck_prev;
  assign tck_fall = ~pins_q.tck & tck_prev;
  assign path = path_of(instr);

  always_comb begin
    next_state = state;
    case (state)
      TAP_RESET: next_state = pins_q.tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_state = pins_q.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_state = pins_q.tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_state = pins_q.tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: next_state = pins_q.tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_state = pins_q.tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: next_state = pins_q.tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: next_state = pins_q.tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: next_state = pins_q.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_state = pins_q.tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: next_state = pins_q.tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: next_state = pins_q.tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_state = pins_q.tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: next_state = pins_q.tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: next_state = pins_q.tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: next_state = pins_q.tms ? TAP_SEL_DR : TAP_IDLE;
      default: next_state = TAP_RESET;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= TAP_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // instruction shift path, sampled on rising tck
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ir_shift <= SBS_IR_RESET;
    end else if (tck_rise) begin
      if (state == TAP_CAP_IR) begin
        ir_shift <= SBS_IR_CAPTURE;
      end else if (state == TAP_SH_IR) begin
        ir_shift <= {pins_q.tdi, ir_shift[SBS_IR_W-1:1]};
      end
    end
  end

  // new instruction takes effect on falling tck in update-ir
  always_ff @(posedge core_clk) begin
    if (srst) begin
      instr <= SBS_IR_RESET;
    end else if (tck_fall) begin
      if (state == TAP_RESET) begin
        instr <= SBS_IR_RESET;
      end else if (state == TAP_UPD_IR) begin
        instr <= ir_shift;
      end
    end
  end

  // boundary register: capture pin levels or defaults, then shift
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bsr <= BSR_DEFAULT;
    end else if (tck_rise && path == PATH_BOUNDARY) begin
      if (state == TAP_CAP_DR) begin
        bsr <= (ring_q & BSR_PIN_MASK) | (BSR_DEFAULT & ~BSR_PIN_MASK);
      end else if (state == TAP_SH_DR) begin
        bsr <= {pins_q.tdi, bsr[BSR_LEN-1:1]};
      end
    end
  end

  // identification register, bit zero leaves first
  always_ff @(posedge core_clk) begin
    if (srst) begin
      id_shift <= ID_VALUE;
    end else if (tck_rise && path == PATH_IDENT) begin
      if (state == TAP_CAP_DR) begin
        id_shift <= ID_VALUE;
      end else if (state == TAP_SH_DR) begin
        id_shift <= {pins_q.tdi, id_shift[SBS_ID_W-1:1]};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bypass_bit <= SBS_BYPASS_CAPTURE;
    end else if (tck_rise && path == PATH_BYPASS) begin
      if (state == TAP_CAP_DR) begin
        bypass_bit <= SBS_BYPASS_CAPTURE;
      end else if (state == TAP_SH_DR) begin
        bypass_bit <= pins_q.tdi;
      end
    end
  end

  // serial output changes on falling tck, enabled only while shifting
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tdo_pin <= '0;
    end else if (tck_fall) begin
      tdo_pin.tdo_oe <= (state == TAP_SH_IR) || (state == TAP_SH_DR);
      if (state == TAP_SH_IR) begin
        tdo_pin.tdo <= ir_shift[0];
      end else begin
        case (path)
          PATH_BOUNDARY: tdo_pin.tdo <= bsr[0];
          PATH_IDENT: tdo_pin.tdo <= id_shift[0];
          PATH_BYPASS: tdo_pin.tdo <= bypass_bit;
          default: tdo_pin.tdo <= bypass_bit;
        endcase
      end
    end
  end

  // parallel output latch loads on falling tck in either update state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ring_out <= BSR_DEFAULT;
    end else if (tck_fall && (state == TAP_UPD_IR || state == TAP_UPD_DR)) begin
      ring_out <= bsr;
    end
  end

  // drive and float controls follow the current instruction
  always_ff @(posedge core_clk) begin
    if (srst) begin
      scan_drive <= 1'b0;
      outputs_float <= 1'b0;
    end else begin
      scan_drive <= (instr == SBS_OP_EXTERNAL);
      outputs_float <= (instr == SBS_OP_SAMPLE_FLOAT);
    end
  end

endmodule : sbs_scan_unit

// [sbs_pkg.sv]
// Purpose: shared constants and types for the memory boundary-scan instruction unit
// Assumes: test port pins arrive asynchronously to core_clk
// Notes: instruction codes read msb left, lsb right
package sbs_pkg;

  localparam int SBS_IR_W = 3;
  localparam int SBS_ID_W = 32;

  localparam logic [2:0] SBS_OP_EXTERNAL = 3'h0;
  localparam logic [2:0] SBS_OP_IDENT = 3'h1;
  localparam logic [2:0] SBS_OP_SAMPLE_FLOAT = 3'h2;
  localparam logic [2:0] SBS_OP_PRELOAD = 3'h4;
  localparam logic [2:0] SBS_OP_BYPASS = 3'h7;

  // fixed pattern loaded in capture-ir, bit 2 taken as zero
  localparam logic [2:0] SBS_IR_CAPTURE = 3'h1;
  localparam logic [2:0] SBS_IR_RESET = SBS_OP_IDENT;

  // arbitrary neutral identification value, lsb set as the scan standard asks
  localparam logic [31:0] SBS_ID_DEFAULT = 32'h0000_0001;

  localparam logic SBS_BYPASS_CAPTURE = 1'h0;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR,
    TAP_EX2_IR, TAP_UPD_IR
  } sbs_tap_e;

  typedef enum logic [1:0] {
    PATH_BOUNDARY, PATH_IDENT, PATH_BYPASS
  } sbs_path_e;

  // test port pins as seen by the block
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbs_pins_s;

  // serial output pin
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } sbs_tdo_s;

endpackage : sbs_pkg

// [sbs_sync.sv]
// Purpose: two-stage synchroniser for a group of asynchronous levels
// Assumes: inputs are levels, not pulses shorter than two core_clk periods
// Notes: only the second stage leaves the module
`timescale 1ns/1ps
module sbs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta;

  // refuse a width the register cannot take
  if (W < 1) begin : g_width_check
    $error("sbs_sync: width must be at least one");
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : sbs_sync

// [sbs_scan_unit_properties.sv]
// Purpose: port-level checks of the boundary-scan instruction unit
// Assumes: tck slow against core_clk
// Notes: bound onto every sbs_scan_unit
`timescale 1ns/1ps
module sbs_scan_unit_properties import sbs_pkg::*; #(
  parameter int BSR_LEN = 16,
  parameter logic [BSR_LEN-1:0] BSR_DEFAULT = '1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // test port
  input wire sbs_pins_s pins,
  input wire sbs_tdo_s tdo_pin,
  // ring and instruction
  input wire logic [BSR_LEN-1:0] ring_out,
  input wire logic scan_drive,
  input wire logic outputs_float,
  input wire logic [SBS_IR_W-1:0] instr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  chk_reset_state: assert property (disable iff (1'b0) srst |=>
    instr == SBS_IR_RESET && ring_out == BSR_DEFAULT && !tdo_pin.tdo_oe) else $error("bad reset");
  chk_drive_code: assert property (!$past(srst) |->
    scan_drive == ($past(instr) == SBS_OP_EXTERNAL)) else $error("drive flag wrong");
  chk_float_code: assert property (!$past(srst) |->
    outputs_float == ($past(instr) == SBS_OP_SAMPLE_FLOAT)) else $error("float flag wrong");
  chk_drive_excl: assert property (!(scan_drive && outputs_float))
    else $error("drive and float together");
  chk_instr_quiet: assert property ($changed(instr) |-> !tdo_pin.tdo_oe)
    else $error("instruction changed while shifting");
  chk_tdo_edge: assert property (!$past(srst) && $changed(tdo_pin.tdo) |-> !$past(pins.tck, 2))
    else $error("tdo moved away from tck fall");
  chk_oe_edge: assert property (!$past(srst) && $rose(tdo_pin.tdo_oe) |->
    !$past(pins.tck, 2) && !pins.tck) else $error("tdo enable rose off tck fall");
  chk_ring_quiet: assert property ($changed(ring_out) |->
    !tdo_pin.tdo_oe && !$past(tdo_pin.tdo_oe)) else $error("ring moved while shifting");
  cover property ($rose(scan_drive));
  cover property ($rose(outputs_float));
  cover property (instr == SBS_OP_BYPASS);
endmodule : sbs_scan_unit_properties

bind sbs_scan_unit sbs_scan_unit_properties #(.BSR_LEN(BSR_LEN), .BSR_DEFAULT(BSR_DEFAULT)) chk (
  .core_clk(core_clk), .srst(srst), .pins(pins), .tdo_pin(tdo_pin), .ring_out(ring_out),
  .scan_drive(scan_drive), .outputs_float(outputs_float), .instr(instr));

// [sbs_jtag_host.sv]
// Purpose: board scan controller driving the test port
// Assumes: 400 ns tck, stopped low between steps
// Notes: tdo sampled at each tck rise
`timescale 1ns/1ps
module sbs_jtag_host import sbs_pkg::*; (
  // test port drive
  output sbs_pins_s pins,
  // serial return
  input wire sbs_tdo_s tdo_pin
);
  initial pins = 3'b001;
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    pins.tms = tms;
    pins.tdi = tdi;
    #200;
    // an undriven tdo line floats, so it reads the inverse of the last level
    tdo = tdo_pin.tdo_oe ? tdo_pin.tdo : ~tdo_pin.tdo;
    pins.tck = 1'b1;
    #200;
    pins.tck = 1'b0;
  endtask : step
  // idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic t;
    dout = '0;
    step(1'b1, 1'b1, t);
    if (ir) step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
    step(1'b0, 1'b1, t);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
  endtask : scan
endmodule : sbs_jtag_host

// [testbench.sv]
// Purpose: self-checking bench for the instruction unit
// Assumes: host model owns the test port
// Notes: expected values from a queue-based shift model
`timescale 1ns/1ps
module testbench import sbs_pkg::*; ;
  localparam int L = 16;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [L-1:0] ring_in = '0;
  sbs_pins_s pins;
  sbs_tdo_s tdo_pin;
  logic [L-1:0] ring_out;
  logic scan_drive;
  logic outputs_float;
  logic [2:0] instr;
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 35;
  sbs_scan_unit #(.BSR_LEN(L)) uut (.core_clk(core_clk), .srst(srst), .pins(pins),
    .tdo_pin(tdo_pin), .ring_in(ring_in), .ring_out(ring_out), .scan_drive(scan_drive),
    .outputs_float(outputs_float), .instr(instr));
  sbs_jtag_host host (.pins(pins), .tdo_pin(tdo_pin));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  task automatic check_word(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic check_flag(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_flag
  // serial register model: captured bits leave first, shifted bits queue behind them
  task automatic model_shift(input int len, input logic [63:0] cap, input logic [63:0] din,
                             input int n, output logic [63:0] out, output logic [63:0] left);
    bit q[$];
    out = '0;
    left = '0;
    for (int i = 0; i < len; i++) q.push_back(cap[i]);
    for (int i = 0; i < n; i++) begin
      out[i] = q.pop_front();
      q.push_back(din[i]);
    end
    for (int i = 0; i < len; i++) left[i] = q[i];
  endtask : model_shift
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    logic [63:0] din;
    logic [63:0] dout;
    logic [63:0] cap;
    logic [63:0] exp;
    logic [63:0] left;
    logic [L-1:0] bsr;
    logic [2:0] code;
    int clen;
    int n;
    repeat (2) @(posedge core_clk);
    #1 srst = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    check_word("instr", 64'(SBS_IR_RESET), 64'(instr));
    host.step(1'b0, 1'b1, dout[0]);
    // preload a pattern before selecting external test
    host.scan(1'b1, 3, 64'(SBS_OP_PRELOAD), dout);
    check_word("ir capture", 64'(3'b001), 64'(dout[2:0]));
    din = {$random(seed), $random(seed)};
    host.scan(1'b0, L, din, dout);
    model_shift(L, 64'(ring_in), din, L, exp, left);
    check_word("preload out", exp, dout);
    bsr = left[L-1:0];
    for (int c = 0; c < 8; c++) begin
      code = 3'(c);
      @(posedge core_clk);
      #1 ring_in = L'($random(seed));
      host.scan(1'b1, 3, 64'(code), dout);
      check_word("instr", 64'(code), 64'(instr));
      check_word("ring out", 64'(bsr), 64'(ring_out));
      check_flag("drive", code == SBS_OP_EXTERNAL, scan_drive);
      check_flag("float", code == SBS_OP_SAMPLE_FLOAT, outputs_float);
      clen = code == SBS_OP_IDENT ? SBS_ID_W :
        (code inside {SBS_OP_EXTERNAL, SBS_OP_SAMPLE_FLOAT, SBS_OP_PRELOAD}) ? L : 1;
      cap = code == SBS_OP_IDENT ? 64'(SBS_ID_DEFAULT) :
        clen == 1 ? 64'(SBS_BYPASS_CAPTURE) : 64'(ring_in);
      din = {$random(seed), $random(seed)};
      n = clen + 8;
      host.scan(1'b0, n, din, dout);
      model_shift(clen, cap, din, n, exp, left);
      check_word("shift out", exp, dout);
      check_flag("tdo enable", 1'b0, tdo_pin.tdo_oe);
      if (clen == L) bsr = left[L-1:0];
      if (code == 3'h0) check_word("ring out", 64'(bsr), 64'(ring_out));
    end
    repeat (5) host.step(1'b1, 1'b1, dout[0]);
    repeat (8) @(posedge core_clk);
    #1 check_word("instr", 64'(SBS_IR_RESET), 64'(instr));
    give_verdict();
  end
endmodule : testbench
